// ===== dcs_pkg.sv
// Shared constants and carrier types for the DDR command sequencing block.
// Assumes a 100 MHz command clock and a 4-bit command code of cs/ras/cas/we.
package dcs_pkg;

  localparam int CLK_PERIOD_NS     = 10;
  localparam int ROW_ACTIVE_MIN_NS = 40;
  localparam int ROW_ACTIVE_MIN_CYC = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_BUSY_NS   = 70;
  localparam int REFRESH_BUSY_CYC  = (REFRESH_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 4;

  localparam int DATA_W            = 16;
  localparam int MASK_W            = DATA_W / 8;
  localparam int ADDR_W            = 13;
  localparam int COL_W             = 3;
  localparam int BANKS             = 4;

  localparam int PRECHARGE_ALL_SELECT_BIT = 10;
  localparam int MR_BL_LSB         = 0;
  localparam int MR_BT_BIT         = 3;
  localparam logic [2:0] RST_BL_CODE = 3'h1;

  localparam logic [3:0] CMD_MODE_SET  = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;

  typedef struct packed {
    logic              cke;
    logic [3:0]        code;
    logic [1:0]        bank;
    logic [ADDR_W-1:0] addr;
  } dcs_cmd_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [MASK_W-1:0] write_byte_mask;
  } dcs_wr_type;

  typedef enum logic [1:0] {PWR_RUN, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF} dcs_pwr_type;
  typedef enum logic [1:0] {BUR_IDLE, BUR_READ, BUR_WRITE} dcs_bur_type;

endpackage : dcs_pkg

// ===== dcs_buf.sv
// Small valid/ready buffer in front of the link crossing.
// Assumes both sides on one clock; full and empty are exact.
`timescale 1ns/1ns
module dcs_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (PW+1)'(in_valid && in_ready) - (PW+1)'(out_valid && out_ready);
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wptr] <= in_data;
    end
  end

endmodule : dcs_buf

// ===== dcs_core.sv
// Command sequencing core of a four-bank DDR device: bank state,
// power-down kind, burst ordering, auto precharge lockout, read data out.
// Assumes commands arrive on ref_clk; read words leave on link_clk.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Power-down with all banks idle becomes precharge power-down.
// - Power-down with any row open becomes active power-down.
// - Precharge with all-select bit high ignores bank inputs, closes every bank.
// - During auto refresh no data, strobe or mask are driven by the device.
// - Read burst words follow the programmed burst order.
// - Auto precharge after read waits for minimum row-active time.
module dcs_core (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 link_clk,
  input  wire dcs_pkg::dcs_cmd_type cmd,
  input  wire dcs_pkg::dcs_wr_type  wr,
  output logic [dcs_pkg::DATA_W-1:0] dq_out,
  output logic                      dq_oe,
  output logic                      dqs_out,
  output logic                      dqs_oe,
  output logic [dcs_pkg::BANKS-1:0] bank_open,
  output dcs_pkg::dcs_pwr_type      power_state,
  output logic                      refresh_busy
);
  import dcs_pkg::*;

  typedef struct packed {
    logic [BANKS-1:0]            open;
    logic [BANKS-1:0][CNT_W-1:0] row_active_min_time;
    logic [BANKS-1:0]            ap;
    logic [2:0]                  bl_code;
    logic                        itl;
    dcs_pwr_type                 pwr;
    dcs_bur_type                 bur;
    logic [1:0]                  b_bank;
    logic [COL_W-1:0]            b_col;
    logic [2:0]                  b_idx;
    logic                        b_ap;
    logic [CNT_W-1:0]            ref_cnt;
    logic [DATA_W-1:0]           hs_data;
    logic                        hs_req;
    logic [2:0]                  ack_sync;
    logic                        ack;
  } dcs_ref_type;

  typedef struct packed {
    logic [2:0]        req_sync;
    logic              ack;
    logic [DATA_W-1:0] dq;
    logic              oe;
    logic              dqs;
  } dcs_link_type;

  dcs_ref_type       s;
  dcs_ref_type       next_s;
  dcs_link_type      l;
  dcs_link_type      next_l;
  logic [DATA_W-1:0] mem [BANKS * (2 ** COL_W)];
  logic [COL_W-1:0]  len_mask;
  logic [COL_W-1:0]  col_now;
  logic              run;
  logic              push;
  logic              push_ready;
  logic              wr_beat;
  logic              last_beat;
  logic              busy;
  logic              pop_valid;
  logic              pop_ready;
  logic [DATA_W-1:0] pop_data;
  logic [BANKS-1:0]  pre_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst order: wrap inside the burst-length block
  assign len_mask = COL_W'((4'h1 << s.bl_code) - 4'h1);
  assign col_now  = (s.b_col & ~len_mask) |
                    ((s.itl ? (s.b_col ^ s.b_idx) : (s.b_col + s.b_idx)) & len_mask);
  assign run       = (s.pwr == PWR_RUN) && cmd.cke;
  assign push      = (s.bur == BUR_READ) && push_ready;
  assign wr_beat   = (s.bur == BUR_WRITE);
  assign last_beat = (s.b_idx == 3'(len_mask));
  assign busy      = (s.hs_req != s.ack);
  assign pop_ready = !busy;

  always_comb begin
    next_s  = s;
    pre_hit = '0;
    next_s.ack_sync = {s.ack_sync[1:0], l.ack};
    if (s.ack_sync[1] == s.ack_sync[2]) begin
      next_s.ack = s.ack_sync[2];
    end
    if (s.ref_cnt != '0) begin
      next_s.ref_cnt = s.ref_cnt - 1'b1;
    end
    for (int b = 0; b < BANKS; b++) begin
      if (s.row_active_min_time[b] != '0) begin
        next_s.row_active_min_time[b] = s.row_active_min_time[b] - 1'b1;
      end
      // Lockout keeps the row open until its minimum active time is over
      if (s.ap[b] && s.row_active_min_time[b] == '0) begin
        next_s.open[b] = 1'b0;
        next_s.ap[b]   = 1'b0;
      end
    end
    if (push || wr_beat) begin
      next_s.b_idx = s.b_idx + 1'b1;
      if (last_beat) begin
        next_s.bur = BUR_IDLE;
        if (s.b_ap) begin
          next_s.ap[s.b_bank] = 1'b1;
        end
      end
    end
    unique case (s.pwr)
      PWR_RUN: begin
        if (!cmd.cke) begin
          if (cmd.code == CMD_REFRESH) begin
            next_s.pwr = PWR_SELF;
          end else if (s.open == '0) begin
            next_s.pwr = PWR_PRE_PD;
          end else begin
            next_s.pwr = PWR_ACT_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD, PWR_SELF: begin
        if (cmd.cke) begin
          next_s.pwr = PWR_RUN;
        end
      end
    endcase
    if (run && s.ref_cnt == '0) begin
      unique case (cmd.code)
        CMD_MODE_SET: begin
          next_s.bl_code = cmd.addr[MR_BL_LSB +: 3];
          next_s.itl     = cmd.addr[MR_BT_BIT];
        end
        CMD_ACTIVATE: begin
          next_s.open[cmd.bank] = 1'b1;
          next_s.row_active_min_time[cmd.bank] = CNT_W'(ROW_ACTIVE_MIN_CYC);
        end
        CMD_PRECHARGE: begin
          // All-select overrides whatever the bank inputs say
          pre_hit = cmd.addr[PRECHARGE_ALL_SELECT_BIT] ? '1 : (BANKS'(1) << cmd.bank);
          next_s.open = next_s.open & ~pre_hit;
          next_s.ap   = next_s.ap & ~pre_hit;
        end
        CMD_REFRESH: begin
          // Refused until buffered read words have crossed, so the link stays quiet
          if (s.bur == BUR_IDLE && !pop_valid && !busy) begin
            next_s.ref_cnt = CNT_W'(REFRESH_BUSY_CYC);
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (s.bur == BUR_IDLE && s.open[cmd.bank]) begin
            next_s.bur    = (cmd.code == CMD_READ) ? BUR_READ : BUR_WRITE;
            next_s.b_bank = cmd.bank;
            next_s.b_col  = cmd.addr[COL_W-1:0];
            next_s.b_idx  = '0;
            next_s.b_ap   = cmd.addr[PRECHARGE_ALL_SELECT_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (pop_valid && pop_ready) begin
      next_s.hs_data = pop_data;
      next_s.hs_req  = !s.hs_req;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s         <= '0;
      s.bl_code <= RST_BL_CODE;
      s.pwr     <= PWR_RUN;
      s.bur     <= BUR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Write beats land in burst order; masked bytes keep old contents
  always_ff @(posedge ref_clk) begin
    if (wr_beat) begin
      for (int k = 0; k < MASK_W; k++) begin
        if (!wr.write_byte_mask[k]) begin
          mem[{s.b_bank, col_now}][k*8 +: 8] <= wr.data[k*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read words wait here so a slow link never drops one
  dcs_buf #(
    .WIDTH (DATA_W),
    .DEPTH (2)
  ) u_buf (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (s.bur == BUR_READ),
    .in_ready  (push_ready),
    .in_data   (mem[{s.b_bank, col_now}]),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Link side: toggle handshake, hs_data stays put until the ack returns
  always_comb begin
    next_l          = l;
    next_l.req_sync = {l.req_sync[1:0], s.hs_req};
    next_l.oe       = 1'b0;
    if (l.req_sync[1] == l.req_sync[2] && l.req_sync[2] != l.ack) begin
      next_l.dq  = s.hs_data;
      next_l.oe  = 1'b1;
      next_l.dqs = !l.dqs;
      next_l.ack = l.req_sync[2];
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign dq_out       = l.dq;
  assign dq_oe        = l.oe;
  assign dqs_out      = l.dqs;
  assign dqs_oe       = l.oe;
  assign bank_open    = s.open;
  assign power_state  = s.pwr;
  assign refresh_busy = (s.ref_cnt != '0);

  ////////////////////////////////////////////////////////////////////////////////
  sequence pd_entry_s;
    s.pwr == PWR_RUN && !cmd.cke && cmd.code != CMD_REFRESH;
  endsequence

  sequence rd_start_s;
    run && s.ref_cnt == '0 && cmd.code == CMD_READ && s.bur == BUR_IDLE && s.open[cmd.bank];
  endsequence

  pd_precharge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pd_entry_s and (s.open == '0) |=> s.pwr == PWR_PRE_PD)
    else $error("idle power-down not precharge kind");
  pd_active_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pd_entry_s and (s.open != '0) |=> s.pwr == PWR_ACT_PD)
    else $error("open-row power-down not active kind");
  pre_all_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run && s.ref_cnt == '0 && cmd.code == CMD_PRECHARGE && cmd.addr[PRECHARGE_ALL_SELECT_BIT]
    |=> s.open == '0)
    else $error("precharge-all left a bank open");
  refresh_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s.ref_cnt != '0 |-> s.bur == BUR_IDLE && !push && !pop_valid && !busy)
    else $error("burst active during refresh");
  burst_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_start_s |=> s.bur == BUR_READ && s.b_idx == 3'h0 && col_now == $past(cmd.addr[COL_W-1:0]))
    else $error("first read word not the addressed column");
  second_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    push && s.b_idx == 3'h1 && !s.itl |-> (col_now & len_mask) == ((s.b_col + 3'h1) & len_mask))
    else $error("sequential order broken");
  for (genvar g = 0; g < BANKS; g++) begin : g_lock
    row_active_min_time_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s.open[g] && !next_s.open[g] && !pre_hit[g] |-> s.row_active_min_time[g] == '0)
      else $error("auto precharge before row-active minimum");
  end

endmodule : dcs_core

// ===== dcs_ctrl_model.sv
// Memory controller model: drives commands and write beats into the core.
// Assumes the core samples cmd and wr on rising ref_clk.
`timescale 1ns/1ns
module dcs_ctrl_model #(
  parameter int MODE_SET_RECOVERY_TIME = 2
) (
  input  wire logic            ref_clk,
  input  wire logic            refresh_busy,
  output dcs_pkg::dcs_cmd_type cmd,
  output dcs_pkg::dcs_wr_type  wr
);
  import dcs_pkg::*;
  localparam logic [3:0] NOP = 4'hF;

  initial begin
    cmd = '{1'b1, NOP, 2'h0, 13'h0000};
    wr  = '0;
  end

  ////////////////////////////////////////
  // Commands wait out a refresh window, the core would drop them silently
  task automatic issue(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] addr, input logic cke);
    @(posedge ref_clk);
    while (refresh_busy === 1'b1)
      @(posedge ref_clk);
    cmd <= '{cke, code, bank, addr};
    @(posedge ref_clk);
    cmd.code <= NOP;
  endtask : issue

  task automatic mode_set(input logic [12:0] mode);
    issue(CMD_MODE_SET, 2'h0, mode, 1'b1);
    repeat (MODE_SET_RECOVERY_TIME) @(posedge ref_clk);
  endtask : mode_set

  task automatic init(input logic [12:0] mode);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    mode_set(13'h0101);
    issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
    issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    mode_set(mode);
    repeat (200) @(posedge ref_clk);
  endtask : init

  task automatic refresh();
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
  endtask : refresh

  task automatic self_refresh();
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b0);
  endtask : self_refresh

  // Raise clock enable, then hold off for the given settle span
  task automatic wake(input int settle);
    @(posedge ref_clk);
    cmd.cke <= 1'b1;
    repeat (settle) @(posedge ref_clk);
  endtask : wake

  task automatic write_burst(input logic [1:0] bank, input logic [12:0] addr, input int bl,
                             input logic [DATA_W-1:0] d [8]);
    @(posedge ref_clk);
    cmd <= '{1'b1, CMD_WRITE, bank, addr};
    for (int i = 0; i < bl; i++) begin
      @(posedge ref_clk);
      cmd.code <= NOP;
      // Mask low on both bytes, so every byte of the beat lands
      wr <= '{d[i], 2'h0};
    end
    @(posedge ref_clk);
    // Released lines show the inverse, never a stale copy
    wr <= ~wr;
  endtask : write_burst
endmodule : dcs_ctrl_model

// ===== ddr_sdram_command_sequencing_test.sv
// Self-checking bench for the DDR command sequencing core.
// Assumes dcs_ctrl_model stands in for the memory controller.
`timescale 1ns/1ns
module ddr_sdram_command_sequencing_test;
  import dcs_pkg::*;
  logic              ref_clk  = 1'b1;
  logic              link_clk = 1'b0;
  logic              sys_rst  = 1'b1;
  dcs_cmd_type       cmd;
  dcs_wr_type        wr;
  logic [DATA_W-1:0] dq_out;
  logic              dq_oe;
  logic              dqs_out;
  logic              dqs_oe;
  logic [BANKS-1:0]  bank_open;
  dcs_pwr_type       power_state;
  logic              refresh_busy;
  int                n_fail = 0;
  int                checks = 0;
  int                seed   = 19;
  logic              dqs_exp = 1'b0;
  logic [DATA_W-1:0] got [$];
  logic [DATA_W-1:0] mem [4][8];
  logic [DATA_W-1:0] d [8];

  // Link clock offset by 2 ns so no edge meets a ref_clk edge
  always #5 ref_clk = ~ref_clk;
  initial begin
    #2;
    forever #15 link_clk = ~link_clk;
  end

  dcs_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .cmd(cmd), .wr(wr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_open(bank_open),
    .power_state(power_state), .refresh_busy(refresh_busy));
  dcs_ctrl_model ctrl (.ref_clk(ref_clk), .refresh_busy(refresh_busy), .cmd(cmd), .wr(wr));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  function automatic logic [2:0] col_at(input logic [2:0] s, input int i, input int bl, input logic il);
    logic [2:0] m;
    m = 3'(bl - 1);
    if (il)
      return s ^ 3'(i);
    return (s & ~m) | ((s + 3'(i)) & m);
  endfunction : col_at

  // Sampled mid-cycle, away from the edge that launches the word
  always @(negedge link_clk) begin
    if (dq_oe === 1'b1) begin
      got.push_back(dq_out);
      dqs_exp = !dqs_exp;
      check(dqs_oe, 1'b1);
      check(dqs_out, dqs_exp);
    end
  end

  initial begin
    #300000;
    n_fail++;
    complete_run();
  end

  initial begin
    logic [2:0] s;
    logic [1:0] b;
    int         bl;
    int         t;
    repeat (6) @(posedge ref_clk);
    check({bank_open, power_state, dq_oe, dqs_oe, refresh_busy}, 32'h0);
    sys_rst <= 1'b0;
    ctrl.init(13'h0002);
    // Every burst length in both orders, random bank, start and data
    for (int k = 0; k < 6; k++) begin
      bl = 2 << (k % 3);
      b = 2'($random(seed));
      ctrl.mode_set({9'h000, k > 2, 3'(k % 3 + 1)});
      ctrl.issue(CMD_ACTIVATE, b, 13'h0000, 1'b1);
      ctrl.issue(CMD_ACTIVATE, b + 2'h1, 13'h0000, 1'b1);
      #1 check(bank_open, (4'h1 << b) | (4'h1 << (b + 2'h1)));
      s = 3'($random(seed));
      for (int i = 0; i < bl; i++) begin
        d[i] = 16'($random(seed));
        mem[b][col_at(s, i, bl, k > 2)] = d[i];
      end
      ctrl.write_burst(b, {10'h000, s}, bl, d);
      s = (s & ~3'(bl - 1)) | 3'($random(seed) & (bl - 1));
      got.delete();
      ctrl.issue(CMD_READ, b, {10'h000, s}, 1'b1);
      for (t = 0; t < 500 && got.size() < bl; t++)
        @(posedge ref_clk);
      for (int i = 0; i < bl; i++)
        check(got[i], mem[b][col_at(s, i, bl, k > 2)]);
      ctrl.issue(4'hF, 2'h0, 13'h0000, 1'b0);
      #1 check(power_state, PWR_ACT_PD);
      ctrl.wake(1);
      ctrl.issue(CMD_PRECHARGE, 2'($random(seed)), 13'h0400, 1'b1);
      #1 check(bank_open, 4'h0);
      ctrl.issue(4'hF, 2'h0, 13'h0000, 1'b0);
      #1 check(power_state, PWR_PRE_PD);
      ctrl.wake(1);
      #1 check(power_state, PWR_RUN);
    end
    // Refresh window: no data or strobe driven
    ctrl.refresh();
    t = 0;
    for (int i = 0; i < 12; i++) begin
      #1 t += int'(refresh_busy === 1'b1);
      check({dq_oe, dqs_oe}, 2'h0);
      @(posedge ref_clk);
    end
    check(t, REFRESH_BUSY_CYC);
    // Short burst with auto precharge right after activate
    ctrl.mode_set(13'h0001);
    got.delete();
    ctrl.issue(CMD_ACTIVATE, 2'h2, 13'h0000, 1'b1);
    ctrl.issue(CMD_READ, 2'h2, 13'h0400, 1'b1);
    for (int i = 0; i < 2; i++) begin
      #1 check(bank_open[2], 1'b1);
      @(posedge ref_clk);
    end
    for (t = 0; t < 60 && (bank_open[2] !== 1'b0 || got.size() < 2); t++)
      @(posedge ref_clk);
    #1 check(bank_open[2], 1'b0);
    check(got.size(), 2);
    ctrl.self_refresh();
    #1 check(power_state, PWR_SELF);
    ctrl.wake(200);
    #1 check(power_state, PWR_RUN);
    complete_run();
  end
endmodule : ddr_sdram_command_sequencing_test
